//--- shared/cram_params.svh
/*
 * Register offsets, field positions and reset values of the receive
 * acceptance mask and buffer status block.
 * Assumes a word-addressed register port with 16-bit data.
 */
`ifndef CRAM_PARAMS_SVH
`define CRAM_PARAMS_SVH

// ****************************************************************
// register offsets (word index on the register port)
// ****************************************************************
`define CRAM_ADDR_W           4
`define CRAM_OFF_MASK0_STD    4'h0
`define CRAM_OFF_MASK1_STD    4'h1
`define CRAM_OFF_MASK2_STD    4'h2
`define CRAM_OFF_MASK0_EXT    4'h3
`define CRAM_OFF_MASK1_EXT    4'h4
`define CRAM_OFF_MASK2_EXT    4'h5
`define CRAM_OFF_FULL_LOW     4'h6
`define CRAM_OFF_FULL_HIGH    4'h7
`define CRAM_OFF_OVR_LOW      4'h8
`define CRAM_OFF_OVR_HIGH     4'h9

// ****************************************************************
// standard mask word fields
// ****************************************************************
`define CRAM_STD_SID_MSB      15
`define CRAM_STD_SID_LSB      5
`define CRAM_STD_UNIMP_HI     4
`define CRAM_STD_TYPE_MATCH   3
`define CRAM_STD_UNIMP_LO     2
`define CRAM_STD_EID_MSB      1
`define CRAM_STD_EID_LSB      0
`define CRAM_STD_IMPL_MASK    16'hffeb

// ****************************************************************
// reset values and counts
// ****************************************************************
`define CRAM_MASK_RESET       16'h0000
`define CRAM_STATUS_RESET     32'h0000_0000
`define CRAM_NUM_MASKS        3
`define CRAM_NUM_BUFFERS      32

`endif

//--- shared/cram_pkg.sv
/*
 * Types of the receive acceptance mask and buffer status block.
 * Assumes cram_params.svh is on the include path.
 */
package cram_pkg;
`include "cram_params.svh"

    // ****************************************************************
    // mask source codes of a filter
    // ****************************************************************
    typedef enum logic [1:0] {
        CRAM_SRC_MASK0    = 2'h0,
        CRAM_SRC_MASK1    = 2'h1,
        CRAM_SRC_MASK2    = 2'h2,
        CRAM_SRC_RESERVED = 2'h3
    } cram_mask_src_t;

    // ****************************************************************
    // whole state of the top module
    // ****************************************************************
    typedef struct packed {
        logic [2:0][15:0] mask_std;
        logic [2:0][15:0] mask_ext;
        logic [31:0]      full;
        logic [31:0]      overrun;
        logic [15:0]      rdata;
        logic             store;
        logic             ovr_event;
        logic [4:0]       buf_idx;
        logic [3:0]       filter_idx;
    } cram_state_t;
endpackage

//--- hdl/cram_filter_match.sv
/*
 * One acceptance filter compared against the frame under a selected mask.
 * Purely combinational; assumes the mask has already been chosen.
 */
`timescale 1ns/10ps
module cram_filter_match
    import cram_pkg::*;
(
    input  wire logic        mask_valid_i,
    input  wire logic [10:0] mask_std_i,
    input  wire logic [17:0] mask_ext_i,
    input  wire logic        frame_type_match_enable_i,
    input  wire logic [10:0] filter_std_ident_bits_i,
    input  wire logic [17:0] filter_ext_ident_bits_i,
    input  wire logic        filter_extended_select_i,
    input  wire logic [10:0] frame_std_ident_bits_i,
    input  wire logic [17:0] frame_ext_ident_bits_i,
    input  wire logic        frame_is_ext_i,
    output logic             hit_o
);
    logic std_equal;
    logic ext_equal;
    logic type_ok;

    // only bits that the mask includes must agree
    assign std_equal = ((filter_std_ident_bits_i ^ frame_std_ident_bits_i)
                        & mask_std_i) == 11'h000;
    assign ext_equal = ((filter_ext_ident_bits_i ^ frame_ext_ident_bits_i)
                        & mask_ext_i) == 18'h00000;

    // with type matching off either format is taken
    assign type_ok = !frame_type_match_enable_i
                     || (filter_extended_select_i == frame_is_ext_i);

    // a standard frame carries no extended bits, so only its id is compared
    assign hit_o = mask_valid_i && type_ok && std_equal
                   && (!frame_is_ext_i || ext_equal);
endmodule

//--- hdl/cram_top.sv
/*
 * Receive acceptance masking and buffer full / overrun status.
 * Assumes filter settings and decoded frame ids come from logic on the
 * same clock; registers are reached over a plain strobe port.
 */
`timescale 1ns/10ps
`include "cram_params.svh"

module cram_top
    import cram_pkg::*;
#(
    parameter int NUM_FILTERS = 16
)
(
    input  wire logic                               clk_i,
    input  wire logic                               reset_n_i,
    input  wire logic [`CRAM_ADDR_W-1:0]            addr_i,
    input  wire logic [15:0]                        wdata_i,
    input  wire logic                               wr_i,
    input  wire logic                               rd_i,
    output logic      [15:0]                        rdata_o,
    input  wire logic [NUM_FILTERS-1:0]             filter_enable_i,
    input  wire logic [NUM_FILTERS-1:0][10:0]       filter_std_ident_bits_i,
    input  wire logic [NUM_FILTERS-1:0][17:0]       filter_ext_ident_bits_i,
    input  wire logic [NUM_FILTERS-1:0]             filter_extended_select_i,
    input  wire logic [NUM_FILTERS-1:0][1:0]        filter_mask_source_i,
    input  wire logic [NUM_FILTERS-1:0][4:0]        filter_buffer_ptr_i,
    input  wire logic                               frame_valid_i,
    input  wire logic [10:0]                        frame_std_ident_bits_i,
    input  wire logic [17:0]                        frame_ext_ident_bits_i,
    input  wire logic                               frame_is_ext_i,
    output logic                                    store_o,
    output logic      [4:0]                         store_buffer_o,
    output logic      [3:0]                         hit_filter_o,
    output logic                                    overrun_o,
    output logic      [31:0]                        rx_buffer_full_flag_o,
    output logic      [31:0]                        rx_buffer_overrun_flag_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    cram_state_t st;
    cram_state_t next_st;

    logic [NUM_FILTERS-1:0] hit_vec;
    logic [NUM_FILTERS-1:0] type_match_sel;
    logic                   any_hit;
    logic [3:0]             win_idx;
    logic [4:0]             win_buf;
    logic                   accept;
    logic                   target_full;
    logic [31:0]            full_set;
    logic [31:0]            ovr_set;
    logic [31:0]            full_clr;
    logic [31:0]            ovr_clr;

    // ****************************************************************
    // per filter mask selection and comparison
    // ****************************************************************
    generate
        for (genvar f = 0; f < NUM_FILTERS; f++)
        begin : g_filter
            logic        sel_valid;
            logic [15:0] sel_std;
            logic [15:0] sel_ext;

            always_comb
            begin
                sel_valid = 1'b1;
                case (cram_mask_src_t'(filter_mask_source_i[f]))
                    CRAM_SRC_MASK0:
                    begin
                        sel_std = st.mask_std[0];
                        sel_ext = st.mask_ext[0];
                    end
                    CRAM_SRC_MASK1:
                    begin
                        sel_std = st.mask_std[1];
                        sel_ext = st.mask_ext[1];
                    end
                    CRAM_SRC_MASK2:
                    begin
                        sel_std = st.mask_std[2];
                        sel_ext = st.mask_ext[2];
                    end
                    default:
                    begin
                        // reserved source never matches rather than guessing a mask
                        sel_valid = 1'b0;
                        sel_std   = 16'h0000;
                        sel_ext   = 16'h0000;
                    end
                endcase
            end

            assign type_match_sel[f] = sel_std[`CRAM_STD_TYPE_MATCH];

            cram_filter_match u_match (
                .mask_valid_i              (sel_valid && filter_enable_i[f]),
                .mask_std_i                (sel_std[`CRAM_STD_SID_MSB:`CRAM_STD_SID_LSB]),
                .mask_ext_i                ({sel_std[`CRAM_STD_EID_MSB:`CRAM_STD_EID_LSB],
                                             sel_ext}),
                .frame_type_match_enable_i (sel_std[`CRAM_STD_TYPE_MATCH]),
                .filter_std_ident_bits_i   (filter_std_ident_bits_i[f]),
                .filter_ext_ident_bits_i   (filter_ext_ident_bits_i[f]),
                .filter_extended_select_i  (filter_extended_select_i[f]),
                .frame_std_ident_bits_i    (frame_std_ident_bits_i),
                .frame_ext_ident_bits_i    (frame_ext_ident_bits_i),
                .frame_is_ext_i            (frame_is_ext_i),
                .hit_o                     (hit_vec[f])
            );
        end
    endgenerate

    // ****************************************************************
    // winning filter: lowest number wins
    // ****************************************************************
    always_comb
    begin
        any_hit = 1'b0;
        win_idx = 4'h0;
        win_buf = 5'h00;
        for (int f = NUM_FILTERS - 1; f >= 0; f--)
        begin
            if (hit_vec[f])
            begin
                any_hit = 1'b1;
                win_idx = 4'(f);
                win_buf = filter_buffer_ptr_i[f];
            end
        end
    end

    assign accept      = frame_valid_i && any_hit;
    assign target_full = st.full[win_buf];

    // ****************************************************************
    // status set and clear terms
    // ****************************************************************
    always_comb
    begin
        full_set = 32'h0000_0000;
        ovr_set  = 32'h0000_0000;
        if (accept && !target_full)
        begin
            full_set[win_buf] = 1'b1;
        end
        if (accept && target_full)
        begin
            ovr_set[win_buf] = 1'b1;
        end
    end

    // only written zeros clear; written ones change nothing
    always_comb
    begin
        full_clr = 32'h0000_0000;
        ovr_clr  = 32'h0000_0000;
        if (wr_i)
        begin
            case (addr_i)
                `CRAM_OFF_FULL_LOW:  full_clr[15:0]  = ~wdata_i;
                `CRAM_OFF_FULL_HIGH: full_clr[31:16] = ~wdata_i;
                `CRAM_OFF_OVR_LOW:   ovr_clr[15:0]   = ~wdata_i;
                `CRAM_OFF_OVR_HIGH:  ovr_clr[31:16]  = ~wdata_i;
                default:             full_clr        = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        next_st            = st;
        next_st.store      = accept && !target_full;
        next_st.ovr_event  = accept && target_full;
        next_st.buf_idx    = accept ? win_buf : st.buf_idx;
        next_st.filter_idx = accept ? win_idx : st.filter_idx;
        next_st.rdata      = 16'h0000;
        // hardware set wins over a software clear in the same cycle
        next_st.full    = (st.full & ~full_clr) | full_set;
        next_st.overrun = (st.overrun & ~ovr_clr) | ovr_set;

        if (wr_i)
        begin
            case (addr_i)
                `CRAM_OFF_MASK0_STD: next_st.mask_std[0] = wdata_i & `CRAM_STD_IMPL_MASK;
                `CRAM_OFF_MASK1_STD: next_st.mask_std[1] = wdata_i & `CRAM_STD_IMPL_MASK;
                `CRAM_OFF_MASK2_STD: next_st.mask_std[2] = wdata_i & `CRAM_STD_IMPL_MASK;
                `CRAM_OFF_MASK0_EXT: next_st.mask_ext[0] = wdata_i;
                `CRAM_OFF_MASK1_EXT: next_st.mask_ext[1] = wdata_i;
                `CRAM_OFF_MASK2_EXT: next_st.mask_ext[2] = wdata_i;
                default:             next_st.rdata       = 16'h0000;
            endcase
        end

        // unmapped reads answer zero
        if (rd_i)
        begin
            case (addr_i)
                `CRAM_OFF_MASK0_STD: next_st.rdata = st.mask_std[0];
                `CRAM_OFF_MASK1_STD: next_st.rdata = st.mask_std[1];
                `CRAM_OFF_MASK2_STD: next_st.rdata = st.mask_std[2];
                `CRAM_OFF_MASK0_EXT: next_st.rdata = st.mask_ext[0];
                `CRAM_OFF_MASK1_EXT: next_st.rdata = st.mask_ext[1];
                `CRAM_OFF_MASK2_EXT: next_st.rdata = st.mask_ext[2];
                `CRAM_OFF_FULL_LOW:  next_st.rdata = st.full[15:0];
                `CRAM_OFF_FULL_HIGH: next_st.rdata = st.full[31:16];
                `CRAM_OFF_OVR_LOW:   next_st.rdata = st.overrun[15:0];
                `CRAM_OFF_OVR_HIGH:  next_st.rdata = st.overrun[31:16];
                default:             next_st.rdata = 16'h0000;
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st            <= '0;
            st.mask_std   <= {3{`CRAM_MASK_RESET}};
            st.mask_ext   <= {3{`CRAM_MASK_RESET}};
            st.full       <= `CRAM_STATUS_RESET;
            st.overrun    <= `CRAM_STATUS_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rdata_o                  = st.rdata;
    assign store_o                  = st.store;
    assign overrun_o                = st.ovr_event;
    assign store_buffer_o           = st.buf_idx;
    assign hit_filter_o             = st.filter_idx;
    assign rx_buffer_full_flag_o    = st.full;
    assign rx_buffer_overrun_flag_o = st.overrun;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    unimpl_bits_zero_a: assert property (
        rd_i && addr_i <= `CRAM_OFF_MASK2_STD |=> rdata_o[4] == 1'b0 && rdata_o[2] == 1'b0)
        else $error("unimplemented mask bits read as one");

    store_sets_full_a: assert property (
        store_o |-> rx_buffer_full_flag_o[store_buffer_o])
        else $error("stored buffer has no full flag");

    zero_clears_only_a: assert property (
        wr_i && addr_i == `CRAM_OFF_FULL_LOW && !frame_valid_i
        |=> rx_buffer_full_flag_o[15:0] == ($past(rx_buffer_full_flag_o[15:0]) & $past(wdata_i)))
        else $error("full flag write did not clear on zero only");

    overrun_sets_flag_a: assert property (
        overrun_o |-> rx_buffer_overrun_flag_o[store_buffer_o] && !store_o)
        else $error("overrun event without overrun flag");

    no_overwrite_full_a: assert property (
        accept && target_full |=> !store_o && overrun_o && store_buffer_o == $past(win_buf))
        else $error("full buffer was overwritten");

    set_beats_clear_a: assert property (
        accept && !target_full && wr_i && addr_i == `CRAM_OFF_FULL_LOW && wdata_i == 16'h0000
        && win_buf < 5'd16 |=> rx_buffer_full_flag_o[store_buffer_o] && store_o)
        else $error("software clear beat hardware set");

    type_match_block_a: assert property (
        type_match_sel[0] && filter_extended_select_i[0] != frame_is_ext_i |-> !hit_vec[0])
        else $error("frame type mismatch still hit");

    reserved_source_a: assert property (
        filter_mask_source_i[0] == 2'b11 |-> !hit_vec[0])
        else $error("reserved mask source produced a hit");

    high_word_read_a: assert property (
        rd_i && addr_i == `CRAM_OFF_FULL_HIGH |=> rdata_o == $past(rx_buffer_full_flag_o[31:16]))
        else $error("high full word does not hold buffers 16 to 31");

    rdata_one_cycle_a: assert property (
        !$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside its cycle");

    store_seen_c:   cover property (store_o);
    overrun_seen_c: cover property (overrun_o ##[1:20] store_o);
    clear_seen_c:   cover property ($fell(rx_buffer_full_flag_o[0]));
    mask_read_c:    cover property (rd_i && addr_i == `CRAM_OFF_MASK1_EXT ##1 rdata_o != 16'h0000);
endmodule

//--- sim/cram_can_node.sv
/*
 * Far-side model: the other bus nodes, seen as decoded frame ids
 * handed to the receive path one frame per call.
 * Assumes the caller samples the answer just after send returns, since
 * send returns on the edge that takes the frame.
 */
`timescale 1ns/10ps
module cram_can_node
(
    input  wire logic        clk_i,
    output logic             frame_valid_o,
    output logic [10:0]      std_o,
    output logic [17:0]      ext_o,
    output logic             is_ext_o
);
    initial
    begin
        frame_valid_o = 1'b0;
        std_o = 11'h7ff;
        ext_o = 18'h0;
        is_ext_o = 1'b0;
    end

    task automatic send(input logic [10:0] s, input logic [17:0] e, input logic x);
        @(posedge clk_i);
        frame_valid_o <= 1'b1;
        std_o <= s;
        ext_o <= e;
        is_ext_o <= x;
        @(posedge clk_i);
        frame_valid_o <= 1'b0;
        // ids are not held after the pulse, so a stale sample cannot pass
        std_o <= ~s;
        ext_o <= ~e;
        is_ext_o <= ~x;
    endtask
endmodule

//--- sim/test_cram_top.sv
/*
 * Self-checking bench of the receive mask and buffer status block.
 * Assumes the register port answers reads one cycle later.
 */
`timescale 1ns/10ps
`include "cram_params.svh"
module test_cram_top
    import cram_pkg::*;
;
    logic             clk_i = 1'b0;
    logic             reset_n_i = 1'b0;
    logic [3:0]       addr_i = 4'h0;
    logic [15:0]      wdata_i = 16'h0;
    logic             wr_i = 1'b0;
    logic             rd_i = 1'b0;
    logic [15:0]      rdata_o;
    logic [3:0]       f_en = 4'h0;
    logic [3:0][10:0] f_std = '0;
    logic [3:0][17:0] f_ext = '0;
    logic [3:0]       f_xs = 4'h0;
    logic [3:0][1:0]  f_src = '0;
    logic [3:0][4:0]  f_ptr = '0;
    logic             fv;
    logic [10:0]      fs;
    logic [17:0]      fe;
    logic             fx;
    logic             store_o;
    logic [4:0]       store_buffer_o;
    logic [3:0]       hit_filter_o;
    logic             overrun_o;
    logic [31:0]      full_o;
    logic [31:0]      ovr_o;
    int               fail_count = 0;
    int               tests_run = 0;
    int               cycles = 0;

    always #12.5 clk_i = ~clk_i;

    cram_can_node node (.clk_i(clk_i), .frame_valid_o(fv), .std_o(fs), .ext_o(fe),
        .is_ext_o(fx));

    cram_top #(.NUM_FILTERS(4)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .filter_enable_i(f_en), .filter_std_ident_bits_i(f_std),
        .filter_ext_ident_bits_i(f_ext), .filter_extended_select_i(f_xs),
        .filter_mask_source_i(f_src), .filter_buffer_ptr_i(f_ptr),
        .frame_valid_i(fv), .frame_std_ident_bits_i(fs), .frame_ext_ident_bits_i(fe),
        .frame_is_ext_i(fx), .store_o(store_o), .store_buffer_o(store_buffer_o),
        .hit_filter_o(hit_filter_o), .overrun_o(overrun_o),
        .rx_buffer_full_flag_o(full_o), .rx_buffer_overrun_flag_o(ovr_o));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", {16'h0, e}, {16'h0, rdata_o});
    endtask

    task automatic setf(input logic [10:0] s, input logic [17:0] e, input logic x,
                        input logic [1:0] src, input logic [4:0] p);
        @(posedge clk_i);
        f_en <= 4'h1;
        f_std[0] <= s;
        f_ext[0] <= e;
        f_xs[0] <= x;
        f_src[0] <= src;
        f_ptr[0] <= p;
    endtask

    // answer stands one cycle after the frame edge only
    task automatic frame(input logic [10:0] s, input logic [17:0] e, input logic x,
                         input logic hit);
        node.send(s, e, x);
        #1;
        chk("hit", {31'h0, hit}, {31'h0, store_o | overrun_o});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        rd(`CRAM_OFF_FULL_LOW, 16'h0);
        rd(`CRAM_OFF_OVR_HIGH, 16'h0);
        for (int n = 0; n < 3; n++)
        begin
            wr(4'(n), 16'hffff);
            wr(4'(n + 3), 16'ha5c0 | 16'(n));
        end
        for (int n = 0; n < 3; n++)
        begin
            rd(4'(n), 16'hffeb);
            rd(4'(n + 3), 16'ha5c0 | 16'(n));
        end
        rd(4'hf, 16'h0);
    endtask

    task automatic t_store();
        setf(11'h123, 18'h0, 1'b0, 2'h0, 5'd3);
        frame(11'h123, 18'h0, 1'b0, 1'b1);
        chk("store", 32'h1, {31'h0, store_o});
        chk("buf", 32'h3, {27'h0, store_buffer_o});
        chk("filter", 32'h0, {28'h0, hit_filter_o});
        chk("full", 32'h8, full_o);
        frame(11'h123, 18'h0, 1'b0, 1'b1);
        chk("ovr pulse", 32'h1, {31'h0, overrun_o});
        chk("no store", 32'h0, {31'h0, store_o});
        chk("ovr flag", 32'h8, ovr_o);
        setf(11'h1, 18'h0, 1'b0, 2'h0, 5'd31);
        frame(11'h1, 18'h0, 1'b0, 1'b1);
        rd(`CRAM_OFF_FULL_HIGH, 16'h8000);
        rd(`CRAM_OFF_FULL_LOW, 16'h0008);
        rd(`CRAM_OFF_OVR_LOW, 16'h0008);
    endtask

    task automatic t_clear();
        wr(`CRAM_OFF_FULL_LOW, 16'hffff);
        rd(`CRAM_OFF_FULL_LOW, 16'h0008);
        wr(`CRAM_OFF_FULL_LOW, 16'hfff7);
        rd(`CRAM_OFF_FULL_LOW, 16'h0);
        wr(`CRAM_OFF_FULL_HIGH, 16'h0);
        rd(`CRAM_OFF_FULL_HIGH, 16'h0);
        setf(11'h2, 18'h0, 1'b0, 2'h0, 5'd5);
        fork
            wr(`CRAM_OFF_FULL_LOW, 16'h0);
            frame(11'h2, 18'h0, 1'b0, 1'b1);
        join
        chk("set wins", 32'h20, full_o);
        wr(`CRAM_OFF_OVR_LOW, 16'h0);
        rd(`CRAM_OFF_OVR_LOW, 16'h0);
        wr(`CRAM_OFF_FULL_LOW, 16'h0);
    endtask

    task automatic t_mask();
        wr(4'h1, 16'hffc0);
        setf(11'h155, 18'h0, 1'b0, 2'h1, 5'd7);
        frame(11'h154, 18'h0, 1'b0, 1'b1);
        frame(11'h157, 18'h0, 1'b0, 1'b0);
        setf(11'h155, 18'h0, 1'b0, 2'h3, 5'd7);
        frame(11'h155, 18'h0, 1'b0, 1'b0);
        wr(4'h1, 16'hffc8);
        setf(11'h155, 18'h0, 1'b0, 2'h1, 5'd7);
        frame(11'h155, 18'h0, 1'b1, 1'b0);
        frame(11'h155, 18'h0, 1'b0, 1'b1);
        setf(11'h155, 18'h0, 1'b1, 2'h1, 5'd7);
        frame(11'h155, 18'h0, 1'b1, 1'b1);
        wr(4'h1, 16'hffc1);
        wr(4'h4, 16'h0001);
        frame(11'h155, 18'h0, 1'b0, 1'b1);
        setf(11'h155, 18'h0, 1'b0, 2'h1, 5'd7);
        frame(11'h155, 18'h0, 1'b1, 1'b1);
        frame(11'h155, 18'h20002, 1'b1, 1'b1);
        frame(11'h155, 18'h10000, 1'b1, 1'b0);
        frame(11'h155, 18'h00001, 1'b1, 1'b0);
    endtask

    // two filters hit: the lower number takes the frame
    task automatic t_prio();
        @(posedge clk_i);
        f_en     <= 4'h6;
        f_std[1] <= 11'h0aa;
        f_std[2] <= 11'h0aa;
        f_src[1] <= 2'h2;
        f_ptr[1] <= 5'd20;
        f_ptr[2] <= 5'd21;
        frame(11'h0aa, 18'h0, 1'b0, 1'b1);
        chk("prio filter", 32'h1, {28'h0, hit_filter_o});
        chk("prio buf", 32'h14, {27'h0, store_buffer_o});
        frame(11'h0aa, 18'h0, 1'b0, 1'b1);
        rd(`CRAM_OFF_FULL_HIGH, 16'h0010);
        rd(`CRAM_OFF_OVR_HIGH, 16'h0010);
        wr(`CRAM_OFF_OVR_HIGH, 16'hffff);
        rd(`CRAM_OFF_OVR_HIGH, 16'h0010);
        wr(`CRAM_OFF_OVR_HIGH, 16'hffef);
        rd(`CRAM_OFF_OVR_HIGH, 16'h0);
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        // tests need well under a thousand cycles
        if (cycles == 3000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_store();
        t_clear();
        t_mask();
        t_prio();
        print_verdict();
    end
endmodule
